// >>> core/dva_pkg.sv
// shared constants and types for the dsp vector add datapath
package dva_pkg;

  localparam int          DATA_W          = 32;
  localparam int          ADDR_W          = 5;
  localparam int          BE_W            = 4;

  // register byte offsets
  localparam logic [4:0]  OFS_SRC_A       = 5'h00;
  localparam logic [4:0]  OFS_SRC_B       = 5'h04;
  localparam logic [4:0]  OFS_CMD         = 5'h08;
  localparam logic [4:0]  OFS_RESULT      = 5'h0C;
  localparam logic [4:0]  OFS_DSP_CTRL    = 5'h10;
  localparam logic [4:0]  OFS_CFG         = 5'h14;
  localparam logic [4:0]  OFS_IRQ_STATUS  = 5'h18;
  localparam logic [4:0]  OFS_IRQ_MASK    = 5'h1C;

  // dsp_control_reg fields
  localparam int          CARRY_BIT       = 13;
  localparam int          OUFLAG_BIT      = 20;
  localparam int          OUFLAG_LSB      = 16;
  localparam int          OUFLAG_MSB      = 23;

  // configuration register fields
  localparam int          CFG_PRESENT_BIT = 0;
  localparam int          CFG_ENABLE_BIT  = 1;

  // interrupt status bits
  localparam int          IRQ_W           = 4;
  localparam int          IRQ_DONE_BIT    = 0;
  localparam int          IRQ_OUFLAG_BIT  = 1;
  localparam int          IRQ_RSVD_BIT    = 2;
  localparam int          IRQ_DIS_BIT     = 3;

  // reset values
  localparam logic [31:0] DSP_CTRL_RST    = 32'h0000_0000;
  localparam logic [1:0]  CFG_RST         = 2'h3;
  localparam logic [3:0]  IRQ_MASK_RST    = 4'h0;

  // saturation limits
  localparam logic [31:0] SAT_POS_W       = 32'h7FFF_FFFF;
  localparam logic [31:0] SAT_NEG_W       = 32'h8000_0000;
  localparam logic [15:0] SAT_U_H         = 16'hFFFF;

  typedef enum logic [2:0] {
    OP_SAT_ADD_FRACT_WORD,
    OP_HALVING_ADD_HALFWORDS,
    OP_ROUNDING_HALVING_ADD_HALFWORDS,
    OP_HALVING_ADD_WORD,
    OP_ROUNDING_HALVING_ADD_WORD,
    OP_ADD_SET_CARRY,
    OP_UNSIGNED_ADD_HALFWORDS,
    OP_UNSIGNED_SAT_ADD_HALFWORDS
  } dva_op_t;

  typedef struct packed {
    logic [31:0] result;
    logic        ouflag;
    logic        carry_wr;
    logic        carry;
  } dva_alu_out_t;

endpackage

// >>> core/dva_datapath.sv
// dsp vector add datapath with avalon-mm register access
//
// Function
// - signed saturating word add clamps on 33-bit sum sign disagreement and flags overflow.
// - halving halfword adds sign-extend elements into 17-bit sums, upper to upper half.
// - non-rounding halving halfword result takes bits 16..1 of each sum.
// - rounding halving halfword adds one before dropping the low bit.
// - halving word add forms a 33-bit sign-extended sum.
// - non-rounding halving word result takes bits 32..1 of the sum.
// - rounding halving word adds one to the 33-bit sum, then takes bits 32..1.
// - halving adds leave every field of the control register unchanged.
// - carry-setting add zero-extends, writes low word and carry-out to bit 13.
// - carry-setting add never touches the overflow flag field.
// - unsigned halfword add wraps each element sum modulo 65,536.
// - saturating unsigned halfword add replaces overflowing element sums with 0xFFFF.
// - both unsigned halfword adds set bit 20 when any element overflows.
// - no operand-dependent exceptions; overflow shows only in results and flags.
// - absent extension raises reserved-instruction, disabled extension raises dsp-disabled.
// - saturating word add sets bit 20 when its result clamps.
//
// The implementer's own choices: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ps

module dva_datapath
  import dva_pkg::*;
(
  input  wire logic                        REF_CLK,
  input  wire logic                        RESET_N,
  input  wire logic [dva_pkg::ADDR_W-1:0]  AVS_ADDRESS,
  input  wire logic                        AVS_READ,
  input  wire logic                        AVS_WRITE,
  input  wire logic [dva_pkg::DATA_W-1:0]  AVS_WRITEDATA,
  input  wire logic [dva_pkg::BE_W-1:0]    AVS_BYTEENABLE,
  output logic      [dva_pkg::DATA_W-1:0]  AVS_READDATA,
  output logic                             AVS_WAITREQUEST,
  output logic                             EXC_RESERVED,
  output logic                             EXC_DSP_DISABLED,
  output logic                             IRQ
);

  // byte-lane merge for partial writes
  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] m;
    m = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
      begin
        m[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return m;
  endfunction

  function automatic dva_alu_out_t dva_compute(input dva_op_t     op,
                                               input logic [31:0] a,
                                               input logic [31:0] b);
    logic [32:0]  s33;
    logic [32:0]  u33;
    logic [16:0]  hi17;
    logic [16:0]  lo17;
    logic [16:0]  uhi;
    logic [16:0]  ulo;
    dva_alu_out_t o;
    s33  = {a[31], a} + {b[31], b};
    u33  = {1'b0, a} + {1'b0, b};
    hi17 = {a[31], a[31:16]} + {b[31], b[31:16]};
    lo17 = {a[15], a[15:0]} + {b[15], b[15:0]};
    uhi  = {1'b0, a[31:16]} + {1'b0, b[31:16]};
    ulo  = {1'b0, a[15:0]} + {1'b0, b[15:0]};
    o    = '0;
    unique case (op)
      OP_SAT_ADD_FRACT_WORD:
      begin
        o.result = s33[31:0];
        if (s33[32] != s33[31])
        begin
          o.result = s33[32] ? SAT_NEG_W : SAT_POS_W;
          o.ouflag = 1'b1;
        end
      end
      OP_HALVING_ADD_HALFWORDS:
      begin
        o.result = {hi17[16:1], lo17[16:1]};
      end
      OP_ROUNDING_HALVING_ADD_HALFWORDS:
      begin
        hi17     = hi17 + 17'h00001;
        lo17     = lo17 + 17'h00001;
        o.result = {hi17[16:1], lo17[16:1]};
      end
      OP_HALVING_ADD_WORD:
      begin
        o.result = s33[32:1];
      end
      OP_ROUNDING_HALVING_ADD_WORD:
      begin
        s33      = s33 + 33'h0_0000_0001;
        o.result = s33[32:1];
      end
      OP_ADD_SET_CARRY:
      begin
        o.result   = u33[31:0];
        o.carry_wr = 1'b1;
        o.carry    = u33[32];
      end
      OP_UNSIGNED_ADD_HALFWORDS:
      begin
        o.result = {uhi[15:0], ulo[15:0]};
        o.ouflag = uhi[16] | ulo[16];
      end
      OP_UNSIGNED_SAT_ADD_HALFWORDS:
      begin
        o.result[31:16] = uhi[16] ? SAT_U_H : uhi[15:0];
        o.result[15:0]  = ulo[16] ? SAT_U_H : ulo[15:0];
        o.ouflag        = uhi[16] | ulo[16];
      end
    endcase
    return o;
  endfunction

  logic              ack_q;
  logic              acc_wr;
  logic              acc_rd;
  logic [31:0]       src_a_q;
  logic [31:0]       src_b_q;
  logic [31:0]       result_q;
  logic [31:0]       dsp_ctrl_q;
  logic [1:0]        cfg_q;
  logic [IRQ_W-1:0]  irq_status_q;
  logic [IRQ_W-1:0]  irq_status_d;
  logic [IRQ_W-1:0]  irq_mask_q;
  logic [IRQ_W-1:0]  irq_event;
  logic              issue;
  logic              exec;
  logic              rsvd_hit;
  logic              dis_hit;
  dva_op_t           op_sel;
  dva_alu_out_t      alu;

  // one wait state: every access is answered on the second edge
  assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack_q;
  assign acc_wr          = AVS_WRITE & ack_q;
  assign acc_rd          = AVS_READ & ack_q;

  always_ff @(posedge REF_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      ack_q <= 1'b0;
    end
    else
    begin
      ack_q <= (AVS_READ | AVS_WRITE) & ~ack_q;
    end
  end

  // read data is captured one edge early so it stands when waitrequest drops
  always_ff @(posedge REF_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      AVS_READDATA <= '0;
    end
    else if (AVS_READ && !ack_q)
    begin
      unique case (AVS_ADDRESS)
        OFS_SRC_A:      AVS_READDATA <= src_a_q;
        OFS_SRC_B:      AVS_READDATA <= src_b_q;
        OFS_RESULT:     AVS_READDATA <= result_q;
        OFS_DSP_CTRL:   AVS_READDATA <= dsp_ctrl_q;
        OFS_CFG:        AVS_READDATA <= {30'h0, cfg_q};
        OFS_IRQ_STATUS: AVS_READDATA <= {28'h0, irq_status_q};
        OFS_IRQ_MASK:   AVS_READDATA <= {28'h0, irq_mask_q};
        default:        AVS_READDATA <= '0;
      endcase
    end
  end

  always_ff @(posedge REF_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      src_a_q <= '0;
      src_b_q <= '0;
    end
    else if (acc_wr)
    begin
      if (AVS_ADDRESS == OFS_SRC_A)
      begin
        src_a_q <= be_merge(src_a_q, AVS_WRITEDATA, AVS_BYTEENABLE);
      end
      if (AVS_ADDRESS == OFS_SRC_B)
      begin
        src_b_q <= be_merge(src_b_q, AVS_WRITEDATA, AVS_BYTEENABLE);
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      cfg_q      <= CFG_RST;
      irq_mask_q <= IRQ_MASK_RST;
    end
    else if (acc_wr && AVS_BYTEENABLE[0])
    begin
      if (AVS_ADDRESS == OFS_CFG)
      begin
        cfg_q <= AVS_WRITEDATA[1:0];
      end
      if (AVS_ADDRESS == OFS_IRQ_MASK)
      begin
        irq_mask_q <= AVS_WRITEDATA[IRQ_W-1:0];
      end
    end
  end

  // a command write issues the operation held in its low three bits
  assign issue    = acc_wr && AVS_ADDRESS == OFS_CMD && AVS_BYTEENABLE[0];
  assign op_sel   = dva_op_t'(AVS_WRITEDATA[2:0]);
  assign rsvd_hit = issue && !cfg_q[CFG_PRESENT_BIT];
  assign dis_hit  = issue && cfg_q[CFG_PRESENT_BIT] && !cfg_q[CFG_ENABLE_BIT];
  // only the configuration gates execution, never the operand values
  assign exec     = issue && cfg_q[CFG_PRESENT_BIT] && cfg_q[CFG_ENABLE_BIT];
  assign alu      = dva_compute(op_sel, src_a_q, src_b_q);

  always_ff @(posedge REF_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      result_q <= '0;
    end
    else if (exec)
    begin
      result_q <= alu.result;
    end
  end

  always_ff @(posedge REF_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      EXC_RESERVED     <= 1'b0;
      EXC_DSP_DISABLED <= 1'b0;
    end
    else
    begin
      EXC_RESERVED     <= rsvd_hit;
      EXC_DSP_DISABLED <= dis_hit;
    end
  end

  // ops only or-in the flag and rewrite the carry; halving ops touch nothing
  always_ff @(posedge REF_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      dsp_ctrl_q <= DSP_CTRL_RST;
    end
    else if (acc_wr && AVS_ADDRESS == OFS_DSP_CTRL)
    begin
      dsp_ctrl_q <= be_merge(dsp_ctrl_q, AVS_WRITEDATA, AVS_BYTEENABLE);
    end
    else if (exec)
    begin
      if (alu.ouflag)
      begin
        dsp_ctrl_q[OUFLAG_BIT] <= 1'b1;
      end
      if (alu.carry_wr)
      begin
        dsp_ctrl_q[CARRY_BIT] <= alu.carry;
      end
    end
  end

  assign irq_event[IRQ_DONE_BIT]   = exec;
  assign irq_event[IRQ_OUFLAG_BIT] = exec & alu.ouflag;
  assign irq_event[IRQ_RSVD_BIT]   = rsvd_hit;
  assign irq_event[IRQ_DIS_BIT]    = dis_hit;

  // a new event in the clearing cycle survives the write-one-to-clear
  always_comb
  begin
    irq_status_d = irq_status_q;
    if (acc_wr && AVS_ADDRESS == OFS_IRQ_STATUS && AVS_BYTEENABLE[0])
    begin
      irq_status_d = irq_status_d & ~AVS_WRITEDATA[IRQ_W-1:0];
    end
    irq_status_d = irq_status_d | irq_event;
  end

  always_ff @(posedge REF_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      irq_status_q <= '0;
    end
    else
    begin
      irq_status_q <= irq_status_d;
    end
  end

  assign IRQ = |(irq_status_q & irq_mask_q);

  // independent reference sums for the checks below
  logic [32:0] chk_s33;
  logic [32:0] chk_u33;
  logic [16:0] chk_hi;
  logic [16:0] chk_lo;
  logic [16:0] chk_uhi;
  logic [16:0] chk_ulo;
  assign chk_s33 = {src_a_q[31], src_a_q} + {src_b_q[31], src_b_q};
  assign chk_u33 = {1'b0, src_a_q} + {1'b0, src_b_q};
  assign chk_hi  = {src_a_q[31], src_a_q[31:16]} + {src_b_q[31], src_b_q[31:16]};
  assign chk_lo  = {src_a_q[15], src_a_q[15:0]} + {src_b_q[15], src_b_q[15:0]};
  assign chk_uhi = {1'b0, src_a_q[31:16]} + {1'b0, src_b_q[31:16]};
  assign chk_ulo = {1'b0, src_a_q[15:0]} + {1'b0, src_b_q[15:0]};

  sat_clamp_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    exec && op_sel == OP_SAT_ADD_FRACT_WORD && chk_s33[32] != chk_s33[31]
    |=> result_q == ($past(chk_s33[32]) ? 32'h8000_0000 : 32'h7FFF_FFFF)
        && dsp_ctrl_q[20])
    else $error("saturating word add did not clamp and flag");

  half_trunc_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    exec && op_sel == OP_HALVING_ADD_HALFWORDS
    |=> result_q == {$past(chk_hi[16:1]), $past(chk_lo[16:1])})
    else $error("halving halfword add result wrong");

  half_round_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    exec && op_sel == OP_ROUNDING_HALVING_ADD_HALFWORDS
    |=> result_q[31:16] == 16'(($past(chk_hi) + 17'h00001) >> 1)
        && result_q[15:0] == 16'(($past(chk_lo) + 17'h00001) >> 1))
    else $error("rounding halving halfword add result wrong");

  word_trunc_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    exec && op_sel == OP_HALVING_ADD_WORD
    |=> result_q == $past(chk_s33[32:1]))
    else $error("halving word add result wrong");

  word_round_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    exec && op_sel == OP_ROUNDING_HALVING_ADD_WORD
    |=> result_q == 32'(($past(chk_s33) + 33'h0_0000_0001) >> 1))
    else $error("rounding halving word add result wrong");

  halving_ctrl_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    exec && (op_sel == OP_HALVING_ADD_HALFWORDS
             || op_sel == OP_ROUNDING_HALVING_ADD_HALFWORDS
             || op_sel == OP_HALVING_ADD_WORD
             || op_sel == OP_ROUNDING_HALVING_ADD_WORD)
    |=> $stable(dsp_ctrl_q))
    else $error("halving add changed the control register");

  carry_set_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    exec && op_sel == OP_ADD_SET_CARRY
    |=> dsp_ctrl_q[13] == $past(chk_u33[32]) && result_q == $past(chk_u33[31:0]))
    else $error("carry-setting add carry or result wrong");

  carry_flag_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    exec && op_sel == OP_ADD_SET_CARRY
    |=> $stable(dsp_ctrl_q[23:16]))
    else $error("carry-setting add touched the overflow field");

  uwrap_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    exec && op_sel == OP_UNSIGNED_ADD_HALFWORDS
    |=> result_q == {$past(chk_uhi[15:0]), $past(chk_ulo[15:0])}
        && (!($past(chk_uhi[16]) | $past(chk_ulo[16])) || dsp_ctrl_q[20]))
    else $error("wrapping unsigned halfword add wrong");

  usat_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    exec && op_sel == OP_UNSIGNED_SAT_ADD_HALFWORDS && chk_uhi[16]
    |=> result_q[31:16] == 16'hFFFF && dsp_ctrl_q[20])
    else $error("saturating unsigned halfword add did not clamp");

  flag_sticky_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    dsp_ctrl_q[20] && !(acc_wr && AVS_ADDRESS == OFS_DSP_CTRL)
    |=> dsp_ctrl_q[20])
    else $error("overflow flag cleared by an operation");

  exc_gate_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    issue && !(cfg_q[0] && cfg_q[1])
    |=> (EXC_RESERVED ^ EXC_DSP_DISABLED) && $stable(result_q) && $stable(dsp_ctrl_q))
    else $error("disabled or absent extension did not trap");

  no_trap_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    issue && cfg_q[0] && cfg_q[1] |=> !EXC_RESERVED && !EXC_DSP_DISABLED ##1 irq_status_q[0])
    else $error("enabled operation raised an exception");

  bus_answer_a: assert property (@(posedge REF_CLK) disable iff (!RESET_N)
    (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("bus access not answered after one wait state");

endmodule

// >>> sim/dva_host.sv
// avalon-mm master model standing in for the pipeline that issues operations
`timescale 1ns/1ps

module dva_host
(
  input  wire logic        clk,
  output logic [4:0]       avs_address,
  output logic             avs_read,
  output logic             avs_write,
  output logic [31:0]      avs_writedata,
  output logic [3:0]       avs_byteenable,
  input  wire logic [31:0] avs_readdata,
  input  wire logic        avs_waitrequest
);

  initial
  begin
    avs_address    = 5'h00;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_writedata  = 32'h0000_0000;
    avs_byteenable = 4'h0;
  end

  // request is held until the rising edge that sees waitrequest low
  task automatic xfer(input logic is_rd, input logic [4:0] addr, input logic [31:0] wdata,
                      input logic [3:0] be, output logic [31:0] rdata, output logic tmo);
    int n;
    @(posedge clk);
    avs_address    <= addr;
    avs_read       <= is_rd;
    avs_write      <= !is_rd;
    avs_writedata  <= wdata;
    avs_byteenable <= be;
    tmo = 1'b1;
    rdata = 32'h0000_0000;
    // sampled at the rising edge itself, before that edge's updates land
    for (n = 0; n < 20; n++)
    begin
      @(posedge clk);
      if (avs_waitrequest === 1'b0)
      begin
        tmo = 1'b0;
        rdata = avs_readdata;
        break;
      end
    end
    avs_read       <= 1'b0;
    avs_write      <= 1'b0;
    // released data lines flip so stale values are never mistaken for live ones
    avs_writedata  <= ~wdata;
    avs_byteenable <= 4'h0;
  endtask

endmodule

// >>> sim/tb.sv
// self-checking testbench of the dsp vector add datapath
`timescale 1ns/1ps

`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin $display("BAD %s exp %h got %h", nm, e, g); n_mismatch++; end end

module tb;
  import dva_pkg::*;

  logic        REF_CLK = 1'b0;
  logic        RESET_N = 1'b0;
  logic [4:0]  AVS_ADDRESS;
  logic        AVS_READ;
  logic        AVS_WRITE;
  logic [31:0] AVS_WRITEDATA;
  logic [3:0]  AVS_BYTEENABLE;
  logic [31:0] AVS_READDATA;
  logic        AVS_WAITREQUEST;
  logic        EXC_RESERVED;
  logic        EXC_DSP_DISABLED;
  logic        IRQ;
  int          n_mismatch = 0;
  int          checked = 0;
  int          n_rsvd = 0;
  int          n_dis = 0;
  logic [31:0] got;
  logic [31:0] exp_v;
  logic [31:0] ctrl_m;
  logic        ov;
  logic        cw;
  logic        cy;
  // operands stay in the integer or fractional formats the operations expect
  logic [31:0] va [6] = '{32'h7FFF_FFFF, 32'h8000_0000, 32'h7FFF_8000, 32'h0001_FFFF,
                          32'hFFFF_0001, 32'h1234_5678};
  logic [31:0] vb [6] = '{32'h0000_0001, 32'hFFFF_FFFF, 32'h0001_8000, 32'h0000_0000,
                          32'h0001_0001, 32'h0FED_CBA9};
  logic [31:0] rst_v [8] = '{32'h0, 32'h0, 32'h0, 32'h0, DSP_CTRL_RST, {30'h0, CFG_RST},
                             32'h0, {28'h0, IRQ_MASK_RST}};

  always #5 REF_CLK = ~REF_CLK;

  dva_datapath i_dut (
    .REF_CLK          (REF_CLK),
    .RESET_N          (RESET_N),
    .AVS_ADDRESS      (AVS_ADDRESS),
    .AVS_READ         (AVS_READ),
    .AVS_WRITE        (AVS_WRITE),
    .AVS_WRITEDATA    (AVS_WRITEDATA),
    .AVS_BYTEENABLE   (AVS_BYTEENABLE),
    .AVS_READDATA     (AVS_READDATA),
    .AVS_WAITREQUEST  (AVS_WAITREQUEST),
    .EXC_RESERVED     (EXC_RESERVED),
    .EXC_DSP_DISABLED (EXC_DSP_DISABLED),
    .IRQ              (IRQ)
  );

  dva_host i_host (
    .clk             (REF_CLK),
    .avs_address     (AVS_ADDRESS),
    .avs_read        (AVS_READ),
    .avs_write       (AVS_WRITE),
    .avs_writedata   (AVS_WRITEDATA),
    .avs_byteenable  (AVS_BYTEENABLE),
    .avs_readdata    (AVS_READDATA),
    .avs_waitrequest (AVS_WAITREQUEST)
  );

  always @(posedge REF_CLK)
  begin
    if (EXC_RESERVED === 1'b1) n_rsvd++;
    if (EXC_DSP_DISABLED === 1'b1) n_dis++;
  end

  task automatic summarize();
    if (n_mismatch == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic wr(input logic [4:0] addr, input logic [31:0] data,
                    input logic [3:0] be = 4'hF);
    logic [31:0] d;
    logic        t;
    i_host.xfer(1'b0, addr, data, be, d, t);
    if (t)
    begin
      n_mismatch++;
      summarize();
    end
  endtask

  task automatic rd(input logic [4:0] addr, output logic [31:0] data);
    logic t;
    i_host.xfer(1'b1, addr, 32'h0000_0000, 4'hF, data, t);
    if (t)
    begin
      n_mismatch++;
      summarize();
    end
  endtask

  function automatic logic [31:0] exp_res(input logic [2:0] op, input logic [31:0] a,
                                          input logic [31:0] b, output logic o,
                                          output logic w, output logic c);
    logic [32:0] sw;
    logic [32:0] sr;
    logic [32:0] uz;
    logic [16:0] hu;
    logic [16:0] hl;
    logic [16:0] uu;
    logic [16:0] ul;
    logic [31:0] r;
    sw = {a[31], a} + {b[31], b};
    sr = sw + 33'h1;
    uz = {1'b0, a} + {1'b0, b};
    hu = {a[31], a[31:16]} + {b[31], b[31:16]};
    hl = {a[15], a[15:0]} + {b[15], b[15:0]};
    uu = {1'b0, a[31:16]} + {1'b0, b[31:16]};
    ul = {1'b0, a[15:0]} + {1'b0, b[15:0]};
    case (op)
      3'h0: r = (sw[32] == sw[31]) ? sw[31:0] : (sw[32] ? SAT_NEG_W : SAT_POS_W);
      3'h1: r = {hu[16:1], hl[16:1]};
      3'h2: r = {hu[16:1] + 16'(hu[0]), hl[16:1] + 16'(hl[0])};
      3'h3: r = sw[32:1];
      3'h4: r = sr[32:1];
      3'h5: r = uz[31:0];
      3'h6: r = {uu[15:0], ul[15:0]};
      default: r = {uu[16] ? SAT_U_H : uu[15:0], ul[16] ? SAT_U_H : ul[15:0]};
    endcase
    o = (op == 3'h0) ? (sw[32] ^ sw[31]) : (op >= 3'h6) ? (uu[16] | ul[16]) : 1'b0;
    w = (op == 3'h5);
    c = uz[32];
    return r;
  endfunction

  initial
  begin
    repeat (20) @(posedge REF_CLK);
    RESET_N <= 1'b1;
    for (int k = 0; k < 8; k++)
    begin
      rd(5'(k * 4), got);
      `CHK("reset value", rst_v[k], got)
    end
    rd(5'h02, got);
    `CHK("unmapped read", 32'h0000_0000, got)
    ctrl_m = 32'h0000_0000;
    for (int p = 0; p < 6; p++)
      for (int op = 0; op < 8; op++)
      begin
        // a carry add always starts from a clear flag so a stray flag write shows
        if (op == 5)
        begin
          wr(OFS_DSP_CTRL, 32'h0000_2000);
          ctrl_m = 32'h0000_2000;
        end
        wr(OFS_SRC_A, va[p]);
        wr(OFS_SRC_B, vb[p]);
        wr(OFS_CMD, 32'(op));
        exp_v = exp_res(3'(op), va[p], vb[p], ov, cw, cy);
        if (ov) ctrl_m[OUFLAG_BIT] = 1'b1;
        if (cw) ctrl_m[CARRY_BIT] = cy;
        rd(OFS_RESULT, got);
        `CHK("result", exp_v, got)
        rd(OFS_DSP_CTRL, got);
        `CHK("dsp_ctrl", ctrl_m, got)
      end
    `CHK("reserved traps", 0, n_rsvd)
    `CHK("disabled traps", 0, n_dis)
    wr(OFS_RESULT, 32'hDEAD_BEEF);
    rd(OFS_RESULT, got);
    `CHK("result read-only", exp_v, got)
    rd(OFS_CMD, got);
    `CHK("cmd reads zero", 32'h0000_0000, got)
    wr(OFS_IRQ_STATUS, 32'h0000_000F);
    wr(OFS_IRQ_MASK, 32'h0000_0001);
    @(negedge REF_CLK);
    `CHK("irq idle", 1'b0, IRQ)
    wr(OFS_CMD, 32'h0000_0003);
    @(negedge REF_CLK);
    `CHK("irq raised", 1'b1, IRQ)
    wr(OFS_IRQ_STATUS, 32'h0000_0001);
    @(negedge REF_CLK);
    `CHK("irq cleared", 1'b0, IRQ)
    wr(OFS_IRQ_MASK, 32'h0000_0000);
    wr(OFS_CMD, 32'h0000_0003);
    @(negedge REF_CLK);
    `CHK("irq masked", 1'b0, IRQ)
    rd(OFS_IRQ_STATUS, got);
    `CHK("done status", 32'h0000_0001, got)
    exp_v = exp_res(3'h3, va[5], vb[5], ov, cw, cy);
    rd(OFS_RESULT, got);
    `CHK("halving word result", exp_v, got)
    rd(OFS_DSP_CTRL, got);
    `CHK("halving dsp_ctrl", ctrl_m, got)
    // absent, present but off, absent but on: absent wins over disabled
    for (int k = 0; k < 3; k++)
    begin
      wr(OFS_CFG, (k == 1) ? 32'h0000_0001 : 32'(k));
      wr(OFS_CMD, 32'h0000_0000);
      rd(OFS_RESULT, got);
      `CHK("trapped result", exp_v, got)
      rd(OFS_DSP_CTRL, got);
      `CHK("trapped dsp_ctrl", ctrl_m, got)
    end
    `CHK("reserved traps", 2, n_rsvd)
    `CHK("disabled traps", 1, n_dis)
    rd(OFS_IRQ_STATUS, got);
    `CHK("trap status", 2'h3, got[IRQ_DIS_BIT:IRQ_RSVD_BIT])
    wr(OFS_CFG, 32'h0000_0003);
    // upper lanes only: the low half of the old operand must survive
    wr(OFS_SRC_A, 32'h7FFF_FFFF, 4'hC);
    rd(OFS_SRC_A, got);
    `CHK("lane merge", 32'h7FFF_5678, got)
    wr(OFS_IRQ_STATUS, 32'h0000_000F);
    wr(OFS_CMD, 32'h0000_0000);
    exp_v = exp_res(3'h0, 32'h7FFF_5678, vb[5], ov, cw, cy);
    rd(OFS_RESULT, got);
    `CHK("clamped result", exp_v, got)
    rd(OFS_IRQ_STATUS, got);
    `CHK("flag status", 32'h0000_0003, got)
    summarize();
  end

endmodule
